/* parameter_access_lock.sv */
// Parameter access lock: lock registers, AHB-Lite slave and access gating
//
// The implementer's own choices: the AHB-Lite slave port and the register addresses.
`timescale 1ns/1ps
module parameter_access_lock (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic [31:0] hrdata,
   output logic hresp,
   // Front keys
   input wire logic key_req,
   input wire pal_pkg::pal_class_type key_class,
   output logic key_grant,
   output logic key_show,
   // RS-485 port
   input wire logic rs_req,
   input wire logic [7:0] rs_item,
   output logic rs_grant,
   // Loader port
   input wire logic ld_req,
   input wire logic [7:0] ld_item,
   output logic ld_grant,
   // Parameter store
   input wire logic uf_item_displayable,
   output logic [1:0] key_lock_level,
   output logic serial_lock,
   output logic loader_lock,
   output logic password_lock
);
   import pal_pkg::*;

   // ----------------------------------------------------------------
   // Storage
   // ----------------------------------------------------------------
   logic [15:0] pw1a;
   logic [15:0] pw2a;
   logic [15:0] pw1b;
   logic [15:0] pw2b;
   logic [8:0] uf_slot [PAL_UF_SLOTS];
   logic refused;
   logic dp_write;
   logic [7:0] dp_addr;
   logic ap_valid;
   logic ap_mapped;
   logic [31:0] next_rdata;
   logic dp_lock;
   logic dp_pw_a;
   logic dp_pw_b;
   logic dp_stat;
   logic dp_uf;
   logic [2:0] dp_uf_idx;
   logic any_denied;
   pal_check_if ck ();

   // Slot number of a byte offset, shared by the read and the write path
   function automatic logic [PAL_UF_IDX_W-1:0] slot_index(input logic [7:0] ofs);
      slot_index = ofs[4:2] - PAL_UF_BASE_OFS[4:2];
   endfunction

   // ----------------------------------------------------------------
   // Permission checker
   // ----------------------------------------------------------------
   pal_checker u_checker (
      .ck(ck)
   );

   assign ck.key_level = key_lock_level;
   assign ck.serial_lock = serial_lock;
   assign ck.loader_lock = loader_lock;
   assign ck.pw_lock = password_lock;
   assign ck.key_class = key_class;
   assign ck.rs_item = rs_item;
   assign ck.ld_item = ld_item;
   // Grants are combinational so a keypress or frame is judged in its own cycle
   assign key_grant = key_req && ck.key_grant;
   assign key_show = ck.key_show;
   assign rs_grant = rs_req && ck.rs_grant;
   assign ld_grant = ld_req && ck.ld_grant;

   // Confirmation copies differ: password lock
   assign password_lock = (pw1a != pw1b) || (pw2a != pw2b);

   // ----------------------------------------------------------------
   // AHB-Lite address phase
   // ----------------------------------------------------------------
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign ap_valid = hsel && htrans[1] && hready;
   assign ap_mapped = (haddr[31:8] == 24'h000000) && (haddr[1:0] == 2'h0) &&
                      (haddr[7:0] <= PAL_UF_LAST_OFS);

   always_comb begin
      next_rdata = PAL_ZERO_WORD;
      if (ap_mapped) begin
         if (haddr[7:0] == PAL_LOCK_OFS) begin
            next_rdata[PAL_LEVEL_LSB +: PAL_LEVEL_W] = key_lock_level;
            next_rdata[PAL_SERIAL_BIT] = serial_lock;
            next_rdata[PAL_LOADER_BIT] = loader_lock;
         end else if (haddr[7:0] == PAL_STAT_OFS) begin
            next_rdata[PAL_STAT_PWLOCK_BIT] = password_lock;
            next_rdata[PAL_STAT_REFUSED_BIT] = refused;
         end else if (haddr[7:0] == PAL_PW_A_OFS) begin
            // Primary password pair reads as zero while locked; the confirmation pair does not
            if (!password_lock) begin
               next_rdata[PAL_PW1_LSB +: PAL_PW_W] = pw1a;
               next_rdata[PAL_PW2_LSB +: PAL_PW_W] = pw2a;
            end
         end else if (haddr[7:0] == PAL_PW_B_OFS) begin
            next_rdata[PAL_PW1_LSB +: PAL_PW_W] = pw1b;
            next_rdata[PAL_PW2_LSB +: PAL_PW_W] = pw2b;
         end else if (haddr[7:0] >= PAL_UF_BASE_OFS) begin
            next_rdata[PAL_UF_VALID_BIT:0] = uf_slot[slot_index(haddr[7:0])];
         end
      end
   end

   // Read data is registered, so it stands during the data phase
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         hrdata <= PAL_ZERO_WORD;
      end else if (ap_valid && !hwrite) begin
         hrdata <= next_rdata;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         dp_write <= 1'b0;
         dp_addr <= 8'h00;
      end else begin
         dp_write <= ap_valid && hwrite && ap_mapped && (hsize == PAL_HSIZE_WORD);
         dp_addr <= haddr[7:0];
      end
   end

   // ----------------------------------------------------------------
   // AHB-Lite data phase decode
   // ----------------------------------------------------------------
   assign dp_lock = dp_write && (dp_addr == PAL_LOCK_OFS);
   assign dp_stat = dp_write && (dp_addr == PAL_STAT_OFS);
   assign dp_pw_a = dp_write && (dp_addr == PAL_PW_A_OFS);
   assign dp_pw_b = dp_write && (dp_addr == PAL_PW_B_OFS);
   assign dp_uf = dp_write && (dp_addr >= PAL_UF_BASE_OFS);
   assign dp_uf_idx = slot_index(dp_addr);

   // ----------------------------------------------------------------
   // Lock settings
   // ----------------------------------------------------------------
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         key_lock_level <= PAL_LVL_ALL;
         serial_lock <= 1'b0;
         loader_lock <= 1'b0;
      end else if (dp_lock && !password_lock) begin
         key_lock_level <= hwdata[PAL_LEVEL_LSB +: PAL_LEVEL_W];
         serial_lock <= hwdata[PAL_SERIAL_BIT];
         loader_lock <= hwdata[PAL_LOADER_BIT];
      end
   end

   // ----------------------------------------------------------------
   // Passwords
   // ----------------------------------------------------------------
   // Writing the primary pair also loads the confirmation pair, so only
   // a later write of a different confirmation value can set the lock.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pw1a <= PAL_PW_RESET;
         pw2a <= PAL_PW_RESET;
      end else if (dp_pw_a && !password_lock) begin
         pw1a <= hwdata[PAL_PW1_LSB +: PAL_PW_W];
         pw2a <= hwdata[PAL_PW2_LSB +: PAL_PW_W];
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pw1b <= PAL_PW_RESET;
         pw2b <= PAL_PW_RESET;
      end else if (dp_pw_b || (dp_pw_a && !password_lock)) begin
         pw1b <= hwdata[PAL_PW1_LSB +: PAL_PW_W];
         pw2b <= hwdata[PAL_PW2_LSB +: PAL_PW_W];
      end
   end

   // ----------------------------------------------------------------
   // User function slots
   // ----------------------------------------------------------------
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         for (int i = 0; i < PAL_UF_SLOTS; i++) begin
            uf_slot[i] <= 9'h000;
         end
      end else if (dp_uf && uf_item_displayable) begin
         uf_slot[dp_uf_idx] <= hwdata[PAL_UF_VALID_BIT:0];
      end
   end

   // ----------------------------------------------------------------
   // Sticky refused flag, write one to clear, a new refusal wins
   // ----------------------------------------------------------------
   assign any_denied = (key_req && !ck.key_grant) || (rs_req && !ck.rs_grant) ||
                       (ld_req && !ck.ld_grant) || (dp_uf && !uf_item_displayable) ||
                       (dp_lock && password_lock);

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         refused <= 1'b0;
      end else if (any_denied) begin
         refused <= 1'b1;
      end else if (dp_stat && hwdata[PAL_STAT_REFUSED_BIT]) begin
         refused <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   // Key level against the four grant sets
   level_all_a: assert property (key_req && key_lock_level == PAL_LVL_ALL |-> key_grant)
      else $error("key change refused at open level");
   level_two_a: assert property (key_req && key_lock_level == PAL_LVL_TWO |->
      key_grant == (key_class != PAL_CLS_OTHER))
      else $error("wrong key grant at level one");
   level_three_a: assert property (key_req && key_lock_level == PAL_LVL_THREE |->
      key_grant == !(key_class inside {PAL_CLS_MODE, PAL_CLS_EVENT, PAL_CLS_OTHER}))
      else $error("wrong key grant at level two");
   level_four_a: assert property (key_req && key_lock_level == PAL_LVL_FOUR |->
      key_grant == (key_class inside {PAL_CLS_USER_FUNCTION, PAL_CLS_LOCK, PAL_CLS_MANUAL,
                                      PAL_CLS_MODE_KEY}))
      else $error("wrong key grant at level three");
   // Port locks and their exempt items
   serial_lock_a: assert property (rs_req |-> rs_grant == (!serial_lock || pal_is_exempt(rs_item)))
      else $error("serial grant mismatch");
   loader_lock_a: assert property (ld_req |-> ld_grant == (!loader_lock || pal_is_exempt(ld_item)))
      else $error("loader grant mismatch");
   show_only_a: assert property (!password_lock |-> key_show)
      else $error("item hidden without password lock");
   pw_hide_a: assert property (key_req && password_lock && !key_grant |-> !key_show)
      else $error("locked item shown under password lock");
   hide_any_a: assert property (password_lock && !ck.key_grant |-> !key_show)
      else $error("locked item shown without a key request");
   exempt_pass_a: assert property (rs_req && pal_is_exempt(rs_item) |-> rs_grant)
      else $error("exempt item refused");
   idle_grant_a: assert property (!rs_req && !ld_req |-> !rs_grant && !ld_grant)
      else $error("port grant without a request");
   // Register writes, slots and password lock
   lock_write_a: assert property (dp_lock && !password_lock |=>
      key_lock_level == $past(hwdata[PAL_LEVEL_LSB +: PAL_LEVEL_W]) &&
      serial_lock == $past(hwdata[PAL_SERIAL_BIT]) && loader_lock == $past(hwdata[PAL_LOADER_BIT]))
      else $error("lock setting write lost");
   slot_guard_a: assert property (dp_uf && !uf_item_displayable |=>
      uf_slot[$past(dp_uf_idx)] == $past(uf_slot[dp_uf_idx]))
      else $error("hidden item put in slot");
   slot_write_a: assert property (dp_uf && uf_item_displayable |=>
      uf_slot[$past(dp_uf_idx)] == $past(hwdata[PAL_UF_VALID_BIT:0]))
      else $error("displayable item not put in slot");
   lock_freeze_a: assert property (password_lock |=>
      $stable({key_lock_level, serial_lock, loader_lock}) || !$past(password_lock))
      else $error("lock setting changed under password lock");
   pw_copy_a: assert property (dp_pw_a && !password_lock |=> !password_lock)
      else $error("primary password write left a lock");
   pw_read_a: assert property (ap_valid && !hwrite && haddr == {24'h000000, PAL_PW_A_OFS} &&
      password_lock |=> hrdata == PAL_ZERO_WORD)
      else $error("password shown under password lock");
   refuse_set_a: assert property (any_denied |=> refused)
      else $error("refusal not recorded");
   reset_zero_a: assert property ($fell(rst) |->
      key_lock_level == PAL_LVL_ALL && !serial_lock && !loader_lock)
      else $error("lock setting not cleared by reset");

   lock_write_c: cover property (dp_lock && !password_lock ##1 serial_lock);
   pw_enter_c: cover property (!password_lock ##1 password_lock);
   exempt_c: cover property (rs_req && serial_lock && rs_grant);
   refuse_c: cover property (key_req && !key_grant && !key_show);
   slot_refuse_c: cover property (dp_uf && !uf_item_displayable);

endmodule // parameter_access_lock

/* pal_pkg.sv */
// Constants, types and permission functions for the parameter access lock
package pal_pkg;

   // ----------------------------------------------------------------
   // Register map (byte offsets)
   // ----------------------------------------------------------------
   localparam logic [7:0] PAL_LOCK_OFS = 8'h00;
   localparam logic [7:0] PAL_STAT_OFS = 8'h04;
   localparam logic [7:0] PAL_PW_A_OFS = 8'h08;
   localparam logic [7:0] PAL_PW_B_OFS = 8'h0C;
   localparam logic [7:0] PAL_UF_BASE_OFS = 8'h10;
   localparam logic [7:0] PAL_UF_LAST_OFS = 8'h2C;
   localparam int PAL_UF_SLOTS = 8;
   localparam int PAL_UF_IDX_W = 3;

   // ----------------------------------------------------------------
   // Field layout
   // ----------------------------------------------------------------
   localparam int PAL_LEVEL_LSB = 0;
   localparam int PAL_LEVEL_W = 2;
   localparam int PAL_SERIAL_BIT = 4;
   localparam int PAL_LOADER_BIT = 5;
   localparam int PAL_PW_W = 16;
   localparam int PAL_PW1_LSB = 0;
   localparam int PAL_PW2_LSB = 16;
   localparam int PAL_ITEM_W = 8;
   localparam int PAL_UF_VALID_BIT = 8;
   localparam int PAL_STAT_PWLOCK_BIT = 0;
   localparam int PAL_STAT_REFUSED_BIT = 1;
   localparam logic [2:0] PAL_HSIZE_WORD = 3'h2;

   // ----------------------------------------------------------------
   // Reset values and key-lock levels
   // ----------------------------------------------------------------
   localparam logic [1:0] PAL_LVL_ALL = 2'h0;
   localparam logic [1:0] PAL_LVL_TWO = 2'h1;
   localparam logic [1:0] PAL_LVL_THREE = 2'h2;
   localparam logic [1:0] PAL_LVL_FOUR = 2'h3;
   localparam logic [15:0] PAL_PW_RESET = 16'h0000;
   localparam logic [31:0] PAL_ZERO_WORD = 32'h00000000;

   // ----------------------------------------------------------------
   // Port item codes that stay reachable under a port lock
   // ----------------------------------------------------------------
   localparam logic [7:0] PAL_ITEM_DECIMAL_POINT = 8'h01;
   localparam logic [7:0] PAL_ITEM_REMOTE_SETPOINT = 8'h02;
   localparam logic [7:0] PAL_ITEM_MODE_FIRST = 8'h10;
   localparam logic [7:0] PAL_ITEM_MODE_LAST = 8'h14;
   localparam logic [7:0] PAL_ITEM_MON_FIRST = 8'h20;
   localparam logic [7:0] PAL_ITEM_MON_LAST = 8'h3F;

   typedef enum logic [3:0] {
      PAL_CLS_MODE = 4'h0,
      PAL_CLS_EVENT = 4'h1,
      PAL_CLS_OPDISP = 4'h2,
      PAL_CLS_SETPOINT = 4'h3,
      PAL_CLS_USER_FUNCTION = 4'h4,
      PAL_CLS_LOCK = 4'h5,
      PAL_CLS_MANUAL = 4'h6,
      PAL_CLS_MODE_KEY = 4'h7,
      PAL_CLS_OTHER = 4'h8
   } pal_class_type;

   // Key change allowed at a given key-lock level
   function automatic logic pal_key_allowed(input logic [1:0] lvl, input pal_class_type cls);
      logic top;
      top = (cls == PAL_CLS_USER_FUNCTION) || (cls == PAL_CLS_LOCK) ||
            (cls == PAL_CLS_MANUAL) || (cls == PAL_CLS_MODE_KEY);
      unique case (lvl)
         PAL_LVL_ALL: pal_key_allowed = 1'b1;
         PAL_LVL_TWO: pal_key_allowed = top || (cls == PAL_CLS_MODE) || (cls == PAL_CLS_EVENT) ||
                                        (cls == PAL_CLS_OPDISP) || (cls == PAL_CLS_SETPOINT);
         PAL_LVL_THREE: pal_key_allowed = top || (cls == PAL_CLS_OPDISP) || (cls == PAL_CLS_SETPOINT);
         PAL_LVL_FOUR: pal_key_allowed = top;
      endcase
   endfunction

   // Items a locked port may still read and write
   function automatic logic pal_is_exempt(input logic [7:0] item);
      pal_is_exempt = (item == PAL_ITEM_DECIMAL_POINT) || (item == PAL_ITEM_REMOTE_SETPOINT) ||
                      ((item >= PAL_ITEM_MODE_FIRST) && (item <= PAL_ITEM_MODE_LAST)) ||
                      ((item >= PAL_ITEM_MON_FIRST) && (item <= PAL_ITEM_MON_LAST));
   endfunction

endpackage

/* pal_check_if.sv */
// Signals between the lock registers and the permission checker
`timescale 1ns/1ps
interface pal_check_if;
   import pal_pkg::*;
   logic [1:0] key_level;
   logic serial_lock;
   logic loader_lock;
   logic pw_lock;
   pal_class_type key_class;
   logic key_grant;
   logic key_show;
   logic [7:0] rs_item;
   logic rs_grant;
   logic [7:0] ld_item;
   logic ld_grant;
   modport regs (output key_level, serial_lock, loader_lock, pw_lock, key_class, rs_item, ld_item,
                 input key_grant, key_show, rs_grant, ld_grant);
   modport chk (input key_level, serial_lock, loader_lock, pw_lock, key_class, rs_item, ld_item,
                output key_grant, key_show, rs_grant, ld_grant);
endinterface

/* pal_checker.sv */
// Combinational permission checker for keys and both ports
`timescale 1ns/1ps
module pal_checker (
   // Lock state and requests
   pal_check_if.chk ck
);
   import pal_pkg::*;

   // ----------------------------------------------------------------
   // Key permission
   // ----------------------------------------------------------------
   always_comb begin
      ck.key_grant = pal_key_allowed(ck.key_level, ck.key_class);
      // Key-locked items stay visible unless the password lock hides them
      ck.key_show = !ck.pw_lock || ck.key_grant;
   end

   // ----------------------------------------------------------------
   // Port permission
   // ----------------------------------------------------------------
   always_comb begin
      ck.rs_grant = !ck.serial_lock || pal_is_exempt(ck.rs_item);
      ck.ld_grant = !ck.loader_lock || pal_is_exempt(ck.ld_item);
   end

endmodule // pal_checker

/* pal_front_model.sv */
// Keypad, RS-485 host and loader port model driving the lock's request pins
`timescale 1ns/1ps
module pal_front_model (
   // Clock
   input wire logic clk,
   // Requests wanted by the bench
   input wire logic want_key,
   input wire pal_pkg::pal_class_type want_class,
   input wire logic want_rs,
   input wire logic [7:0] want_rs_item,
   input wire logic want_ld,
   input wire logic [7:0] want_ld_item,
   // Pins toward the lock
   output pal_pkg::pal_class_type key_class,
   output logic key_req,
   output logic rs_req,
   output logic [7:0] rs_item,
   output logic ld_req,
   output logic [7:0] ld_item
);
   import pal_pkg::*;
   // Released item lines flip so no stale code looks valid
   always @(posedge clk) begin
      key_req <= want_key;
      key_class <= want_class;
      rs_req <= want_rs;
      rs_item <= want_rs ? want_rs_item : ~rs_item;
      ld_req <= want_ld;
      ld_item <= want_ld ? want_ld_item : ~ld_item;
   end
endmodule // pal_front_model

/* test_parameter_access_lock.sv */
// Self-checking testbench for the parameter access lock
`timescale 1ns/1ps
module test_parameter_access_lock;
   import pal_pkg::*;
   logic clk, rst, hsel, hwrite, uf, wk, wr, wl, elsl, elll, epw;
   logic [31:0] haddr, hwdata, q, ex_slot [8];
   logic [1:0] htrans, elvl;
   logic [2:0] hsize;
   logic [7:0] wri, wli, corner [11];
   pal_class_type wc, key_class;
   wire logic hreadyout, hresp, key_grant, key_show, rs_grant, ld_grant, serial_lock, loader_lock, password_lock;
   wire logic key_req, rs_req, ld_req;
   wire logic [31:0] hrdata;
   wire logic [7:0] rs_item, ld_item;
   wire logic [1:0] key_lock_level;
   int errors, compares, seed, u;
   parameter_access_lock u_parameter_access_lock (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .key_req(key_req), .key_class(key_class),
      .key_grant(key_grant), .key_show(key_show), .rs_req(rs_req), .rs_item(rs_item), .rs_grant(rs_grant),
      .ld_req(ld_req), .ld_item(ld_item), .ld_grant(ld_grant), .uf_item_displayable(uf),
      .key_lock_level(key_lock_level), .serial_lock(serial_lock), .loader_lock(loader_lock),
      .password_lock(password_lock));
   pal_front_model u_pal_front_model (.clk(clk), .want_key(wk), .want_class(wc), .want_rs(wr),
      .want_rs_item(wri), .want_ld(wl), .want_ld_item(wli), .key_class(key_class), .key_req(key_req),
      .rs_req(rs_req), .rs_item(rs_item), .ld_req(ld_req), .ld_item(ld_item));
   // ----------------------------------------------------------------
   // Expectations
   // ----------------------------------------------------------------
   function automatic logic kok(input logic [1:0] l, input int c);
      case (l)
         2'h0: kok = 1'b1;
         2'h1: kok = c <= 7;
         2'h2: kok = c >= 2 && c <= 7;
         default: kok = c >= 4 && c <= 7;
      endcase
   endfunction
   function automatic logic exm(input logic [7:0] i);
      exm = i == 8'h01 || i == 8'h02 || (i >= 8'h10 && i <= 8'h14) || (i >= 8'h20 && i <= 8'h3F);
   endfunction
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
      compares++;
      if (s !== e) begin
         errors++;
         $display("MISMATCH %s expected %h seen %h", n, e, s);
      end
   endtask
   // ----------------------------------------------------------------
   // AHB-Lite master, entered just after a rising edge
   // ----------------------------------------------------------------
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
      haddr <= {24'h000000, a};
      htrans <= 2'h2;
      hwrite <= w;
      hsize <= PAL_HSIZE_WORD;
      @(posedge clk);
      while (hreadyout !== 1'b1) @(posedge clk);
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge clk);
      while (hreadyout !== 1'b1) @(posedge clk);
      r = hrdata;
      chk("hresp", 32'h00000000, {31'h00000000, hresp});
   endtask
   task automatic wreg(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d, q);
   endtask
   task automatic rchk(input string n, input logic [7:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h00000000, q);
      chk(n, e, q);
   endtask
   // Drives the far side, then compares all grants against the model state
   task automatic port(input logic k, input int c, input logic r, input logic [7:0] ri, input logic [7:0] li);
      wk <= k;
      wc <= pal_class_type'(c);
      wr <= r;
      wri <= ri;
      wl <= ~r;
      wli <= li;
      @(posedge clk);
      @(posedge clk);
      #1;
      chk("key_grant", k && kok(elvl, c), key_grant);
      chk("key_show", !(epw && !kok(elvl, c)), key_show);
      chk("rs_grant", r && (!elsl || exm(ri)), rs_grant);
      chk("ld_grant", !r && (!elll || exm(li)), ld_grant);
      @(posedge clk);
   endtask
   task automatic end_sim;
      $display("errors %0d compares %0d", errors, compares);
      if (errors == 0 && compares > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // Whole run is about 1150 cycles
   initial begin
      #200000;
      errors++;
      end_sim;
   end
   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      seed = 5654;
      {rst, hsel, haddr, htrans, hwrite, hsize, hwdata, uf} = {1'b1, 1'b1, 32'h0, 2'h0, 1'b0, 3'h0, 32'h0, 1'b0};
      {wk, wr, wl, wri, wli, elvl, elsl, elll, epw} = {3'h0, 16'h0, 5'h0};
      wc = PAL_CLS_OTHER;
      corner = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h10, 8'h14, 8'h15, 8'h1F, 8'h20, 8'h3F, 8'h40};
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      chk("reset flags", 4'h0, {key_lock_level, serial_lock, loader_lock});
      rchk("lock reg", PAL_LOCK_OFS, 32'h00000000);
      for (int v = 0; v < 16; v++) begin
         {elll, elsl, elvl} = v[3:0];
         wreg(PAL_LOCK_OFS, {26'h0, elll, elsl, 2'h0, elvl});
         rchk("lock reg", PAL_LOCK_OFS, {26'h0, elll, elsl, 2'h0, elvl});
         chk("lock pins", {elvl, elsl, elll}, {key_lock_level, serial_lock, loader_lock});
         for (int c = 0; c < 9; c++) port(1'b1, c, c[0], 8'($random(seed)), 8'($random(seed)));
         for (int j = 0; j < 11; j++) begin
            port(1'($random(seed)), {$random(seed)} % 9, j[0], corner[j], corner[j]);
         end
      end
      rchk("status refused", PAL_STAT_OFS, 32'h00000002);
      port(1'b0, 8, 1'b0, 8'h00, 8'h00);
      wl <= 1'b0;
      @(posedge clk);
      wreg(PAL_STAT_OFS, 32'h00000002);
      rchk("status cleared", PAL_STAT_OFS, 32'h00000000);
      {elll, elsl, elvl} = 4'h2;
      wreg(PAL_LOCK_OFS, 32'h00000002);
      wreg(PAL_PW_A_OFS, 32'h12345678);
      rchk("pw b copy", PAL_PW_B_OFS, 32'h12345678);
      rchk("pw a open", PAL_PW_A_OFS, 32'h12345678);
      wreg(PAL_PW_B_OFS, 32'h92345678);
      @(posedge clk);
      chk("password_lock", 1'b1, password_lock);
      epw = 1'b1;
      rchk("pw a hidden", PAL_PW_A_OFS, 32'h00000000);
      wreg(PAL_LOCK_OFS, 32'h00000033);
      rchk("lock frozen", PAL_LOCK_OFS, 32'h00000002);
      for (int c = 0; c < 9; c++) port(1'b1, c, 1'b1, 8'h05, 8'h05);
      wreg(PAL_PW_B_OFS, 32'h12345678);
      @(posedge clk);
      chk("password_lock", 1'b0, password_lock);
      epw = 1'b0;
      for (int i = 0; i < 8; i++) begin
         u = (i == 0) ? 1 : (i == 7) ? 0 : $random(seed);
         uf <= u[0];
         ex_slot[i] = {$random(seed)} & 32'h000001FF;
         wreg(PAL_UF_BASE_OFS + 8'(4 * i), ex_slot[i]);
         if (!u[0]) ex_slot[i] = 32'h00000000;
      end
      for (int i = 0; i < 8; i++) rchk("slot", PAL_UF_BASE_OFS + 8'(4 * i), ex_slot[i]);
      wreg(8'h30, 32'hFFFFFFFF);
      rchk("unmapped", 8'h30, 32'h00000000);
      // Reset in mid-run must drop every lock setting and the first slot again
      wreg(PAL_LOCK_OFS, 32'h00000031);
      rchk("lock reg", PAL_LOCK_OFS, 32'h00000031);
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      chk("reset flags", 4'h0, {key_lock_level, serial_lock, loader_lock});
      rchk("slot reset", PAL_UF_BASE_OFS, 32'h00000000);
      end_sim;
   end
endmodule // test_parameter_access_lock
